/* hw/dpf_pkg.sv */
// Constants and types shared by the digital port fault and inhibit block
package dpf_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_PIN_FUNC = 8'h00;
	localparam logic [7:0] OFF_PIN_POL  = 8'h04;
	localparam logic [7:0] OFF_OUT_DATA = 8'h08;
	localparam logic [7:0] OFF_IN_DATA  = 8'h0C;
	localparam logic [7:0] OFF_INH_MODE = 8'h10;
	localparam logic [7:0] OFF_PROT_CLR = 8'h14;
	localparam logic [7:0] OFF_STATUS   = 8'h18;

	// Pin count, field layout and special pins (index = pin number - 1)
	localparam int          NPINS      = 7;
	localparam int          FUNC_W     = 2;
	localparam int          PIN_ALARM  = 0;
	localparam int          PIN_COMMON = 1;
	localparam int          PIN_INH    = 2;
	localparam int          CLR_BIT    = 0;

	// Pin function codes
	localparam logic [1:0] FN_BIDIR   = 2'h0;
	localparam logic [1:0] FN_INPUT   = 2'h1;
	localparam logic [1:0] FN_ALARM   = 2'h2;
	localparam logic [1:0] FN_DISCON  = 2'h3;

	// Inhibit mode codes
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_LIVE  = 2'h1;
	localparam logic [1:0] MODE_LATCH = 2'h2;

	// Values after reset
	localparam logic [13:0] RST_PIN_FUNC = 14'h1555;
	localparam logic [6:0]  RST_PIN_POL  = 7'h00;
	localparam logic [6:0]  RST_OUT_DATA = 7'h00;
	localparam logic [1:0]  RST_INH_MODE = MODE_OFF;

	// Status bit positions
	localparam int ST_FAULT_LAT = 0;
	localparam int ST_INH_LAT   = 1;
	localparam int ST_FAULT_OUT = 2;
	localparam int ST_DISCON    = 3;
	localparam int ST_ERROR     = 4;

	// Timing: longest allowed inhibit latency, rounded down to cycles
	localparam int CLK_PERIOD_NS     = 50;
	localparam int INH_LATENCY_NS    = 5000;
	localparam int INH_LATENCY_CYC   = INH_LATENCY_NS / CLK_PERIOD_NS;

	typedef logic [1:0] dpf_mode_t;

endpackage

/* hw/dpf_prot_if.sv */
// Carrier between the port front end and the protection engine
`timescale 1ns/1ns
interface dpf_prot_if;
	logic              clear_pulse;
	dpf_pkg::dpf_mode_t mode;
	logic              inh_active;
	logic              fault_cond;
	logic              fault_lat;
	logic              inh_lat;
	logic              fault_active;
	logic              disconnect;
	logic              error;

	modport ctl (
		output clear_pulse, mode, inh_active, fault_cond,
		input  fault_lat, inh_lat, fault_active, disconnect, error
	);
	modport eng (
		input  clear_pulse, mode, inh_active, fault_cond,
		output fault_lat, inh_lat, fault_active, disconnect, error
	);
endinterface

/* hw/dpf_prot.sv */
// Protection engine: fault latch, inhibit handling and error indicator
`timescale 1ns/1ns
module dpf_prot (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Front end
	dpf_prot_if.eng   pif
);

	logic fault_lat_r, fault_lat_nxt;
	logic inh_lat_r,   inh_lat_nxt;
	logic fault_act_r, fault_act_nxt;
	logic discon_r,    discon_nxt;
	logic error_r,     error_nxt;
	logic blank_r,     blank_nxt;
	logic live_inh;
	logic live_fault;

	always_comb begin
		live_inh      = (pif.mode == dpf_pkg::MODE_LIVE) && pif.inh_active;
		// A loop back through the chain is two edges deep, so the live term is held off on the
		// clear edge and the one after; a held external inhibit shows a two-cycle gap on the output
		blank_nxt     = pif.clear_pulse;
		live_fault    = live_inh && !pif.clear_pulse && !blank_r;
		fault_lat_nxt = fault_lat_r;
		inh_lat_nxt   = inh_lat_r;
		// Clear only takes when the cause is gone; a cause present wins
		if (pif.clear_pulse && !pif.fault_cond)
			fault_lat_nxt = 1'b0;
		if (pif.fault_cond)
			fault_lat_nxt = 1'b1;
		if (pif.mode != dpf_pkg::MODE_LATCH)
			inh_lat_nxt = 1'b0;
		else if (pif.inh_active)
			inh_lat_nxt = 1'b1;
		else if (pif.clear_pulse)
			inh_lat_nxt = 1'b0;
		// Live inhibit feeds the chain unlatched, so one clear breaks the loop
		fault_act_nxt = fault_lat_nxt | inh_lat_nxt | live_fault;
		discon_nxt    = live_inh | inh_lat_nxt;
		error_nxt     = error_r;
		if (pif.clear_pulse && !pif.inh_active && !pif.fault_cond)
			error_nxt = 1'b0;
		if (live_inh || inh_lat_nxt || pif.fault_cond)
			error_nxt = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_lat_r <= 1'b0;
			inh_lat_r   <= 1'b0;
			fault_act_r <= 1'b0;
			discon_r    <= 1'b0;
			error_r     <= 1'b0;
			blank_r     <= 1'b0;
		end else begin
			fault_lat_r <= fault_lat_nxt;
			inh_lat_r   <= inh_lat_nxt;
			fault_act_r <= fault_act_nxt;
			discon_r    <= discon_nxt;
			error_r     <= error_nxt;
			blank_r     <= blank_nxt;
		end
	end

	assign pif.fault_lat    = fault_lat_r;
	assign pif.inh_lat      = inh_lat_r;
	assign pif.fault_active = fault_act_r;
	assign pif.disconnect   = discon_r;
	assign pif.error        = error_r;

endmodule // dpf_prot

/* hw/dpf_port.sv */
// Digital control port top: AHB-Lite registers, pin functions, fault output and inhibit input
//
// Overview of operation
// - input pins report external level after polarity
// - input-only pins ignore the output data word
// - fault pair only pins 1/2; pin 2 ignored
// - fault output follows the protection fault summary
// - positive polarity: fault makes output conduct
// - fault latched until cause gone and cleared
// - pin 3 inhibit disconnects all channels
// - inhibit is level sensitive, within 5 us
// - inhibit modes off, live and latching
// - any inhibit lights error until removed, cleared
// - chained fault stays until separately cleared
// - live mode: one unit's clear frees chain
// - only the clear command clears protection (the inhibit latch also drops when latch mode is left)
// - pins 1 to 7 map bits 0 to 6
// - pin 1 leaving fault sets pin 2 input
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module dpf_port (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port pins, bit n is pin n+1
	input  wire logic [6:0]  pin_in,
	output logic      [6:0]  pin_out,
	output logic      [6:0]  pin_oe_n,
	// Instrument side
	input  wire logic        fault_cond,
	output logic             disconnect_all,
	output logic             error_led
);

	dpf_prot_if pif ();

	dpf_prot u_prot (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pif     (pif)
	);

	// Field of one pin within the function register
	function automatic logic [1:0] fn_of(input logic [13:0] cfg, input int idx);
		fn_of = cfg[idx*dpf_pkg::FUNC_W +: dpf_pkg::FUNC_W];
	endfunction

	// Bus state
	logic        ph_valid_r, ph_valid_nxt;
	logic        ph_write_r, ph_write_nxt;
	logic [7:0]  ph_addr_r,  ph_addr_nxt;
	logic        hready_r,   hready_nxt;
	logic [31:0] hrdata_r,   hrdata_nxt;
	logic        hresp_r,    hresp_nxt;

	// Register state
	logic [13:0] func_r,  func_nxt;
	logic [6:0]  pol_r,   pol_nxt;
	logic [6:0]  odata_r, odata_nxt;
	dpf_pkg::dpf_mode_t mode_r, mode_nxt;
	logic        clr_r,   clr_nxt;

	// Pin state
	logic [6:0]  pin_out_r,  pin_out_nxt;
	logic [6:0]  pin_oe_n_r, pin_oe_n_nxt;

	logic        addr_take;
	logic        wr_commit;
	logic [6:0]  in_level;
	logic [13:0] func_wr;
	logic [1:0]  fw;
	logic [31:0] rd_mux;

	assign addr_take = hsel && htrans[1] && hready;
	assign wr_commit = ph_valid_r && ph_write_r;
	assign in_level  = pin_in ^ pol_r;

	// Bus phase tracking; reads take one wait state so hrdata sees committed writes
	always_comb begin
		ph_valid_nxt = ph_valid_r;
		ph_write_nxt = ph_write_r;
		ph_addr_nxt  = ph_addr_r;
		hready_nxt   = 1'b1;
		hrdata_nxt   = hrdata_r;
		// Every transfer is answered OKAY; registered like the other bus outputs
		hresp_nxt    = 1'b0;
		if (ph_valid_r && !ph_write_r && !hready_r) begin
			hrdata_nxt   = rd_mux;
			ph_valid_nxt = 1'b0;
		end else if (hready_r) begin
			ph_valid_nxt = addr_take;
			ph_write_nxt = hwrite;
			ph_addr_nxt  = haddr[7:0];
			if (addr_take && !hwrite)
				hready_nxt = 1'b0;
		end else begin
			hready_nxt = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= 8'h00;
			hready_r   <= 1'b1;
			hrdata_r   <= 32'h00000000;
			hresp_r    <= 1'b0;
		end else begin
			ph_valid_r <= ph_valid_nxt;
			ph_write_r <= ph_write_nxt;
			ph_addr_r  <= ph_addr_nxt;
			hready_r   <= hready_nxt;
			hrdata_r   <= hrdata_nxt;
			hresp_r    <= hresp_nxt;
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h00000000;
		case (ph_addr_r)
			dpf_pkg::OFF_PIN_FUNC: rd_mux = {18'h00000, func_r};
			dpf_pkg::OFF_PIN_POL:  rd_mux = {25'h0000000, pol_r};
			dpf_pkg::OFF_OUT_DATA: rd_mux = {25'h0000000, odata_r};
			dpf_pkg::OFF_IN_DATA:  rd_mux = {25'h0000000, in_level};
			dpf_pkg::OFF_INH_MODE: rd_mux = {30'h00000000, mode_r};
			dpf_pkg::OFF_STATUS: begin
				rd_mux[dpf_pkg::ST_FAULT_LAT] = pif.fault_lat;
				rd_mux[dpf_pkg::ST_INH_LAT]   = pif.inh_lat;
				rd_mux[dpf_pkg::ST_FAULT_OUT] = pif.fault_active;
				rd_mux[dpf_pkg::ST_DISCON]    = pif.disconnect;
				rd_mux[dpf_pkg::ST_ERROR]     = pif.error;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Legalise a function write pin by pin
	always_comb begin
		func_wr = func_r;
		fw      = 2'h0;
		for (int i = 0; i < dpf_pkg::NPINS; i++) begin
			fw = hwdata[i*dpf_pkg::FUNC_W +: dpf_pkg::FUNC_W];
			if (fw == dpf_pkg::FN_ALARM && i != dpf_pkg::PIN_ALARM)
				fw = fn_of(func_r, i);
			if (fw == dpf_pkg::FN_DISCON && i != dpf_pkg::PIN_INH)
				fw = fn_of(func_r, i);
			func_wr[i*dpf_pkg::FUNC_W +: dpf_pkg::FUNC_W] = fw;
		end
		if (fn_of(func_wr, dpf_pkg::PIN_ALARM) == dpf_pkg::FN_ALARM)
			func_wr[dpf_pkg::PIN_COMMON*dpf_pkg::FUNC_W +: dpf_pkg::FUNC_W] = dpf_pkg::FN_ALARM;
		else if (fn_of(func_r, dpf_pkg::PIN_ALARM) == dpf_pkg::FN_ALARM)
			func_wr[dpf_pkg::PIN_COMMON*dpf_pkg::FUNC_W +: dpf_pkg::FUNC_W] = dpf_pkg::FN_INPUT;
	end

	// Register writes in the data phase
	always_comb begin
		func_nxt  = func_r;
		pol_nxt   = pol_r;
		odata_nxt = odata_r;
		mode_nxt  = mode_r;
		clr_nxt   = 1'b0;
		if (wr_commit) begin
			case (ph_addr_r)
				dpf_pkg::OFF_PIN_FUNC: func_nxt = func_wr;
				dpf_pkg::OFF_PIN_POL:  pol_nxt = hwdata[6:0];
				dpf_pkg::OFF_OUT_DATA: odata_nxt = hwdata[6:0];
				dpf_pkg::OFF_INH_MODE: begin
					// Code 3 is not a mode; such a write is dropped
					if (hwdata[1:0] != 2'h3)
						mode_nxt = hwdata[1:0];
				end
				dpf_pkg::OFF_PROT_CLR: clr_nxt = hwdata[dpf_pkg::CLR_BIT];
				default: clr_nxt = 1'b0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_r  <= dpf_pkg::RST_PIN_FUNC;
			pol_r   <= dpf_pkg::RST_PIN_POL;
			odata_r <= dpf_pkg::RST_OUT_DATA;
			mode_r  <= dpf_pkg::RST_INH_MODE;
			clr_r   <= 1'b0;
		end else begin
			func_r  <= func_nxt;
			pol_r   <= pol_nxt;
			odata_r <= odata_nxt;
			mode_r  <= mode_nxt;
			clr_r   <= clr_nxt;
		end
	end

	// Protection engine inputs; off mode masks the pin entirely
	assign pif.clear_pulse = clr_r;
	assign pif.mode        = mode_r;
	assign pif.fault_cond  = fault_cond;
	assign pif.inh_active  = (fn_of(func_r, dpf_pkg::PIN_INH) == dpf_pkg::FN_DISCON)
	                         && (mode_r != dpf_pkg::MODE_OFF)
	                         && in_level[dpf_pkg::PIN_INH];

	// Pin drivers; only the bidirectional and alarm functions drive
	always_comb begin
		pin_out_nxt  = 7'h00;
		pin_oe_n_nxt = 7'h7F;
		for (int i = 0; i < dpf_pkg::NPINS; i++) begin
			case (fn_of(func_r, i))
				dpf_pkg::FN_BIDIR: begin
					pin_out_nxt[i]  = odata_r[i] ^ pol_r[i];
					pin_oe_n_nxt[i] = 1'b0;
				end
				dpf_pkg::FN_ALARM: begin
					// Pin 2 is the isolated common and is never driven
					if (i == dpf_pkg::PIN_ALARM) begin
						pin_out_nxt[i]  = pif.fault_active ^ pol_r[i];
						pin_oe_n_nxt[i] = 1'b0;
					end
				end
				default: begin
					pin_out_nxt[i]  = 1'b0;
					pin_oe_n_nxt[i] = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out_r  <= 7'h00;
			pin_oe_n_r <= 7'h7F;
		end else begin
			pin_out_r  <= pin_out_nxt;
			pin_oe_n_r <= pin_oe_n_nxt;
		end
	end

	assign hrdata         = hrdata_r;
	assign hreadyout      = hready_r;
	assign hresp          = hresp_r;
	assign pin_out        = pin_out_r;
	assign pin_oe_n       = pin_oe_n_r;
	assign disconnect_all = pif.disconnect;
	assign error_led      = pif.error;

endmodule // dpf_port

/* tb/dpf_port_asserts.sv */
// Checker for bus timing, fault output and error indicator at the digital port top
`timescale 1ns/1ns
module dpf_port_asserts (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pins and instrument
	input wire logic [6:0]  pin_out,
	input wire logic [6:0]  pin_oe_n,
	input wire logic        fault_cond,
	input wire logic        disconnect_all,
	input wire logic        error_led
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic        take;
	logic        wp_r, wp_nxt;
	logic [7:0]  wa_r, wa_nxt;
	logic [13:0] fn_r, fn_nxt;
	logic [6:0]  pol_r, pol_nxt;
	logic [2:0]  age_r, age_nxt;
	assign take = hsel && htrans[1] && hready;
	// Shadow of the written configuration; illegal function codes are never written by the bench
	always_comb begin
		wp_nxt = take && hwrite;
		wa_nxt = take ? haddr[7:0] : wa_r;
		fn_nxt = fn_r;
		pol_nxt = pol_r;
		age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
		if (wp_r && wa_r == dpf_pkg::OFF_PIN_FUNC) fn_nxt = hwdata[13:0];
		if (wp_r && wa_r == dpf_pkg::OFF_PIN_POL) pol_nxt = hwdata[6:0];
		if (take && hwrite && haddr[7:0] == dpf_pkg::OFF_PROT_CLR) age_nxt = 3'h0;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_r <= 1'b0;
			wa_r <= 8'h00;
			fn_r <= dpf_pkg::RST_PIN_FUNC;
			pol_r <= 7'h00;
			age_r <= 3'h7;
		end else begin
			wp_r <= wp_nxt;
			wa_r <= wa_nxt;
			fn_r <= fn_nxt;
			pol_r <= pol_nxt;
			age_r <= age_nxt;
		end
	end
	sequence s_rd; take && !hwrite; endsequence
	sequence s_wait; !hreadyout ##1 hreadyout; endsequence
	property p_rd_wait; s_rd |=> s_wait; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read not answered after one wait");
	property p_wr_fast; take && hwrite |=> hreadyout; endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write phase stalled");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rd_hold; $changed(hrdata) |-> $past(!hreadyout); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed outside a read");
	property p_fault_err; fault_cond |-> ##[1:2] error_led; endproperty
	a_fault_err: assert property (p_fault_err) else $error("fault did not light error");
	property p_err_keep; error_led && fault_cond |=> error_led; endproperty
	a_err_keep: assert property (p_err_keep) else $error("error dropped with fault present");
	property p_err_clr; $fell(error_led) |-> age_r < 3'h7; endproperty
	a_err_clr: assert property (p_err_clr) else $error("error cleared without clear write");
	property p_fault_drv;
		fault_cond && fn_r[1:0] == dpf_pkg::FN_ALARM && !pol_r[0] |-> ##2 (pin_out[0] && !pin_oe_n[0]);
	endproperty
	a_fault_drv: assert property (p_fault_drv) else $error("fault output not conducting");
	property p_in_hiz; fn_r[7:6] == dpf_pkg::FN_INPUT && $stable(fn_r) |-> pin_oe_n[3]; endproperty
	a_in_hiz: assert property (p_in_hiz) else $error("input-only pin driven");
	property p_discon_err; disconnect_all |-> error_led; endproperty
	a_discon_err: assert property (p_discon_err) else $error("disconnect without error light");
endmodule // dpf_port_asserts

bind dpf_port dpf_port_asserts u_dpf_port_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_out, .pin_oe_n, .fault_cond, .disconnect_all,
	.error_led);

/* tb/dpf_far_end.sv */
// Outside circuit at the port pins with an optional fault-to-inhibit loop
`timescale 1ns/1ns
module dpf_far_end (
	// Outside sources
	input wire logic [6:0] ext_lvl,
	input wire logic       chain,
	// Port pins
	input wire logic [6:0] pin_out,
	input wire logic [6:0] pin_oe_n,
	output logic     [6:0] pin_in
);
	logic [6:0] lvl;
	// A driven pin overrides the outside source
	assign lvl = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
	// Chain of one: own fault output feeds own inhibit, same polarity on both
	assign pin_in = chain ? {lvl[6:3], lvl[0], lvl[1:0]} : lvl;
endmodule // dpf_far_end

/* tb/dpf_port_tb.sv */
// Self-checking bench for the digital port top
`timescale 1ns/1ns
module dpf_port_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        fault_cond = 1'b0, chain = 1'b0, rd_dp = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
	logic [6:0]  ext = 7'h0, pin_in, pin_out, pin_oe_n, p;
	logic        hreadyout, hresp, disconnect_all, error_led;
	logic [31:0] exq[$], mkq[$];
	logic [31:0] st[3] = '{32'h0, 32'h1C, 32'h1E};
	logic [31:0] sr[3] = '{32'h0, 32'h10, 32'h1E};
	int          failures = 0, num_checks = 0, cyc = 0, tn = 0;
	always #25 hclk = ~hclk;
	dpf_port u_dpf_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe_n, .fault_cond,
		.disconnect_all, .error_led);
	dpf_far_end u_dpf_far_end (.ext_lvl(ext), .chain, .pin_out, .pin_oe_n, .pin_in);
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		exq.push_back(e);
		mkq.push_back(m);
		ahb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic clr;
		wr(dpf_pkg::OFF_PROT_CLR, 32'h1);
		repeat (4) @(posedge hclk);
	endtask
	task automatic done;
		tn++;
		$display("test %0d done", tn);
	endtask
	// Results are compared as each read data phase completes
	always @(posedge hclk) if (rd_dp && hreadyout) chk(hrdata & mkq.pop_front(), exq.pop_front());
	// Generous ceiling: the sequence needs well under a thousand cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			finish_test;
		end
	end
	initial begin
		void'($urandom(85));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(dpf_pkg::OFF_PIN_FUNC, 32'h1555);
		rd(dpf_pkg::OFF_PIN_POL, 32'h0);
		rd(dpf_pkg::OFF_STATUS, 32'h0);
		rd(8'h1C, 32'h0);
		wr(dpf_pkg::OFF_INH_MODE, 32'h3);
		rd(dpf_pkg::OFF_INH_MODE, 32'h0);
		done;
		repeat (4) begin
			ext <= 7'($urandom);
			p = 7'($urandom);
			v = $urandom;
			wr(dpf_pkg::OFF_PIN_POL, {25'h0, p});
			wr(dpf_pkg::OFF_OUT_DATA, v);
			rd(dpf_pkg::OFF_IN_DATA, {25'h0, ext ^ p});
		end
		wr(dpf_pkg::OFF_PIN_POL, 32'h0);
		ext <= 7'h0;
		done;
		wr(dpf_pkg::OFF_PIN_FUNC, 32'h1556);
		wr(dpf_pkg::OFF_PIN_FUNC, 32'h1552);
		rd(dpf_pkg::OFF_PIN_FUNC, 32'h155A);
		fault_cond <= 1'b1;
		clr;
		rd(dpf_pkg::OFF_STATUS, 32'h15);
		rd(dpf_pkg::OFF_IN_DATA, 32'h1);
		fault_cond <= 1'b0;
		rd(dpf_pkg::OFF_STATUS, 32'h15);
		clr;
		rd(dpf_pkg::OFF_STATUS, 32'h0);
		wr(dpf_pkg::OFF_PIN_FUNC, 32'h1550);
		rd(dpf_pkg::OFF_PIN_FUNC, 32'h1554);
		done;
		wr(dpf_pkg::OFF_PIN_FUNC, 32'h1575);
		for (int m = 0; m < 3; m++) for (int n = 0; n < 2; n++) begin
			wr(dpf_pkg::OFF_INH_MODE, 32'(m));
			wr(dpf_pkg::OFF_PIN_POL, {29'h0, n[0], 2'h0});
			// With negative polarity a switch shorting pin 3 to common is the active level
			ext <= {4'h0, ~n[0], 2'h0};
			repeat (4) @(posedge hclk);
			rd(dpf_pkg::OFF_STATUS, st[m]);
			ext <= {4'h0, n[0], 2'h0};
			repeat (4) @(posedge hclk);
			rd(dpf_pkg::OFF_STATUS, sr[m]);
			clr;
			rd(dpf_pkg::OFF_STATUS, 32'h0);
		end
		done;
		wr(dpf_pkg::OFF_PIN_POL, 32'h0);
		ext <= 7'h0;
		wr(dpf_pkg::OFF_INH_MODE, {30'h0, dpf_pkg::MODE_LIVE});
		wr(dpf_pkg::OFF_PIN_FUNC, 32'h1576);
		chain <= 1'b1;
		fault_cond <= 1'b1;
		@(posedge hclk);
		fault_cond <= 1'b0;
		repeat (6) @(posedge hclk);
		rd(dpf_pkg::OFF_STATUS, 32'h1D);
		clr;
		rd(dpf_pkg::OFF_STATUS, 32'h0, 32'hF);
		clr;
		wr(dpf_pkg::OFF_INH_MODE, {30'h0, dpf_pkg::MODE_LATCH});
		fault_cond <= 1'b1;
		@(posedge hclk);
		fault_cond <= 1'b0;
		repeat (6) @(posedge hclk);
		rd(dpf_pkg::OFF_STATUS, 32'h1F);
		// Latched chain is broken by turning the inhibit off, then re-armed
		wr(dpf_pkg::OFF_INH_MODE, {30'h0, dpf_pkg::MODE_OFF});
		repeat (4) @(posedge hclk);
		clr;
		wr(dpf_pkg::OFF_INH_MODE, {30'h0, dpf_pkg::MODE_LATCH});
		repeat (4) @(posedge hclk);
		rd(dpf_pkg::OFF_STATUS, 32'h0);
		done;
		finish_test;
	end
endmodule // dpf_port_tb
